// *** logic/lsb_pkg.sv ***
package lsb_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_DATA = 8'h04;
   localparam logic [7:0] OFF_CTRL1 = 8'h08;
   localparam logic [7:0] OFF_CTRL2 = 8'h0C;
   localparam logic [7:0] OFF_CTRL3 = 8'h10;
   localparam logic [7:0] OFF_HLEN = 8'h14;
   localparam logic [7:0] OFF_MASK = 8'h18;
   localparam logic [7:0] OFF_BAUD = 8'h1C;
   // status bit positions
   localparam int ST_RXF = 0;
   localparam int ST_HDF = 1;
   localparam int ST_HERR = 2;
   localparam int ST_TXDONE = 3;
   // control bit positions
   localparam int C1_WLS = 0;
   localparam int C2_BRK = 0;
   localparam int C2_TXON = 1;
   localparam int C2_MUTE = 2;
   localparam int C2_RXON = 3;
   localparam int C3_LIN = 0;
   // timing in bit periods and samples
   localparam int SAMPLES_PER_BIT = 16;
   localparam logic [3:0] SAMPLE_LAST = 4'hF;
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [7:0] HDR_MAX_BITS = 8'h39;
   localparam logic [4:0] BRK_BITS_8 = 5'h0A;
   localparam logic [4:0] BRK_BITS_9 = 5'h0B;
   localparam logic [4:0] BRK_BITS_LIN = 5'h0D;
   localparam logic [4:0] IDLE_BITS = 5'h0A;
   localparam logic [7:0] HLEN_TIMEOUT = 8'h00;
   // reset value and sync byte
   localparam logic [15:0] BAUD_RST = 16'h0044;
   localparam logic [7:0] SYNC_BYTE = 8'h55;
   typedef enum logic [1:0] {TX_IDLE, TX_GAP, TX_BREAK} lsb_tx_t;
   typedef enum logic [2:0] {HD_WAIT, HD_BREAK, HD_SYNC, HD_ID, HD_DATA} lsb_hd_t;
endpackage

// *** logic/lsb_rxbyte.sv ***
`timescale 1ns/1ps
`default_nettype none
// byte receiver: start, 8 or 9 data bits, stop
module lsb_rxbyte (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // sampling
   input wire logic tick_in,
   input wire logic rx_in,
   input wire logic nine_in,
   // results
   output logic done_out,
   output logic [7:0] data_out,
   output logic framing_out,
   output logic bit_out,
   output logic last_sample_out
);
   logic busy_q, busy_d;
   logic [3:0] smp_q, smp_d;
   logic [3:0] bit_q, bit_d;
   logic [8:0] sh_q, sh_d;
   logic done_d, fr_d, bit_d2, last_d;
   logic [3:0] nbits;
   always_comb begin
      busy_d = busy_q;
      smp_d = smp_q;
      bit_d = bit_q;
      sh_d = sh_q;
      done_d = 1'b0;
      fr_d = framing_out;
      bit_d2 = 1'b0;
      last_d = 1'b0;
      nbits = nine_in ? 4'hA : 4'h9;
      if (tick_in) begin
         if (!busy_q) begin
            // after a framing error wait for the line to go high, so a long break is not read twice
            if (!rx_in && !framing_out) begin
               busy_d = 1'b1;
               smp_d = 4'h1;
               bit_d = 4'h0;
            end else if (rx_in) begin
               fr_d = 1'b0;
            end
         end else begin
            smp_d = smp_q + 4'h1;
            last_d = (smp_q == lsb_pkg::SAMPLE_LAST);
            if (smp_q == lsb_pkg::SAMPLE_MID) begin
               bit_d2 = 1'b1;
               if (bit_q == 4'h0 && rx_in) begin
                  busy_d = 1'b0;
               end else if (bit_q == nbits) begin
                  busy_d = 1'b0;
                  done_d = 1'b1;
                  fr_d = !rx_in;
               end else begin
                  sh_d = {rx_in, sh_q[8:1]};
                  bit_d = bit_q + 4'h1;
               end
            end
         end
      end
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         busy_q <= 1'b0;
         smp_q <= 4'h0;
         bit_q <= 4'h0;
         sh_q <= 9'h000;
         done_out <= 1'b0;
         data_out <= 8'h00;
         framing_out <= 1'b0;
         bit_out <= 1'b0;
         last_sample_out <= 1'b0;
      end else begin
         busy_q <= busy_d;
         smp_q <= smp_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         done_out <= done_d;
         data_out <= nine_in ? sh_d[7:0] : sh_d[8:1];
         framing_out <= fr_d;
         bit_out <= bit_d2;
         last_sample_out <= last_d;
      end
   end
endmodule
`default_nettype wire

// *** logic/lsb_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
// sixteen sample ticks per bit from a programmable divisor
module lsb_tick (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // divisor
   input wire logic [15:0] div_in,
   // tick
   output logic tick_out
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic tick_d;
   always_comb begin
      tick_d = (cnt_q >= div_in);
      cnt_d = tick_d ? 16'h0000 : cnt_q + 16'h0001;
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cnt_q <= 16'h0000;
         tick_out <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_out <= tick_d;
      end
   end
endmodule
`default_nettype wire

// *** logic/lsb_top.sv ***
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] In LIN slave mode a header longer than 57 bit periods sets the header error flag, interrupts, and keeps the receiver muted.
// [R2] The receiver samples the line sixteen times in each bit period.
// [R3] On a header time-out the header-found flag stays clear and mute is never left, even in the identifier stop bit.
// [R4] A header time-out loads the header length register with zero.
// [R5] Reading status then reading data clears the header error flag.
// [R6] Unmuted with receive-on, each good byte (in LIN mode only after a header) sets receive-full and interrupts; writing the mute bit re-mutes the receiver.
// [R7] Setting then clearing send-break sends one break of 10 bit periods, or 11 with nine-bit words.
// [R8] While send-break stays set, break characters keep being sent.
// [R9] LIN enable with word length clear is LIN master mode, where a break lasts 13 bit periods.
// [R10] Clearing then setting transmit-on queues an idle, and a break asked for next follows it at full length.
// [R11] Software should keep interrupts off between the idle request and the break request.
// [R12] The idle inserted before a break lasts ten bit periods.
// [R13] A break holds the transmit line low for its whole length, then the line returns high.
module lsb_top (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line
   input wire logic rx_in,
   output logic tx_out,
   // interrupt
   output logic irq_out
);
   logic tick, rb_done, rb_fr;
   logic [7:0] rb_data;
   logic [3:0] status_q, status_d;
   logic [3:0] mask_q, mask_d;
   logic [7:0] data_q, data_d;
   logic wls_q, wls_d, lin_q, lin_d;
   logic brk_q, brk_d, txon_q, txon_d, mute_q, mute_d, rxon_q, rxon_d;
   logic [7:0] hlen_q, hlen_d;
   logic [15:0] baud_q, baud_d;
   logic st_read_q, st_read_d;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d, irq_d;
   lsb_pkg::lsb_tx_t txs_q, txs_d;
   logic [3:0] tsmp_q, tsmp_d;
   logic [4:0] tbit_q, tbit_d;
   logic idle_req_q, idle_req_d, tx_d, brk_req_q, brk_req_d;
   lsb_pkg::lsb_hd_t hds_q, hds_d;
   logic [7:0] hbits_q, hbits_d;
   logic [3:0] hsmp_q, hsmp_d;
   logic access, wr, rd;
   logic hd_timeout, hd_found;

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
      is_reg = (a == off);
   endfunction

   lsb_tick u_tick (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .div_in(baud_q),
      .tick_out(tick)
   );

   lsb_rxbyte u_rx (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .tick_in(tick), // [R2]
      .rx_in(rx_in),
      .nine_in(wls_q),
      .done_out(rb_done),
      .data_out(rb_data),
      .framing_out(rb_fr),
      .bit_out(),
      .last_sample_out()
   );

   assign access = psel && penable && !pready;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;

   // header tracker for slave mode: break, sync, identifier, then data
   always_comb begin
      hds_d = hds_q;
      hbits_d = hbits_q;
      hsmp_d = hsmp_q;
      hd_timeout = 1'b0;
      hd_found = 1'b0;
      if (!lin_q || !rxon_q) begin
         hds_d = lsb_pkg::HD_WAIT;
         hbits_d = 8'h00;
         hsmp_d = 4'h0;
      end else begin
         // header length runs on the sample tick, so an idle line still counts
         if (hds_q != lsb_pkg::HD_WAIT && hds_q != lsb_pkg::HD_DATA && tick) begin
            hsmp_d = hsmp_q + 4'h1;
            if (hsmp_q == lsb_pkg::SAMPLE_LAST) hbits_d = hbits_q + 8'h01; // [R2]
         end
         case (hds_q)
            lsb_pkg::HD_WAIT: begin
               if (rb_done && rb_fr && rb_data == 8'h00) begin
                  hds_d = lsb_pkg::HD_SYNC;
                  hbits_d = 8'h0B;
                  hsmp_d = 4'h0;
               end
            end
            lsb_pkg::HD_BREAK: hds_d = lsb_pkg::HD_SYNC;
            lsb_pkg::HD_SYNC: begin
               if (rb_done) begin
                  hds_d = (rb_data == lsb_pkg::SYNC_BYTE && !rb_fr) ? lsb_pkg::HD_ID
                                                                   : lsb_pkg::HD_WAIT;
               end
            end
            lsb_pkg::HD_ID: begin
               if (rb_done && !rb_fr) begin
                  hds_d = lsb_pkg::HD_DATA;
                  hd_found = 1'b1;
               end
            end
            lsb_pkg::HD_DATA: begin
               if (rb_done && rb_fr && rb_data == 8'h00) begin
                  hds_d = lsb_pkg::HD_SYNC;
                  hbits_d = 8'h0B;
                  hsmp_d = 4'h0;
               end
            end
            default: hds_d = lsb_pkg::HD_WAIT;
         endcase
         // time-out overrides everything, including the id stop bit
         if ((hds_q == lsb_pkg::HD_SYNC || hds_q == lsb_pkg::HD_ID)
             && hbits_q > lsb_pkg::HDR_MAX_BITS) begin // [R1]
            hd_timeout = 1'b1;
            hd_found = 1'b0; // [R3]
            hds_d = lsb_pkg::HD_WAIT;
            hbits_d = 8'h00;
            hsmp_d = 4'h0;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         hds_q <= lsb_pkg::HD_WAIT;
         hbits_q <= 8'h00;
         hsmp_q <= 4'h0;
      end else begin
         hds_q <= hds_d;
         hbits_q <= hbits_d;
         hsmp_q <= hsmp_d;
      end
   end

   // registers, flags and the apb answer
   always_comb begin
      status_d = status_q;
      mask_d = mask_q;
      data_d = data_q;
      wls_d = wls_q;
      lin_d = lin_q;
      brk_d = brk_q;
      txon_d = txon_q;
      mute_d = mute_q;
      rxon_d = rxon_q;
      hlen_d = hlen_q;
      baud_d = baud_q;
      st_read_d = st_read_q;
      idle_req_d = idle_req_q;
      brk_req_d = brk_req_q;
      prdata_d = 32'h0000_0000;
      pready_d = access;
      pslverr_d = 1'b0;
      // a served request is dropped before any new write, so a new request wins
      if (txs_q == lsb_pkg::TX_BREAK) brk_req_d = 1'b0;
      if (rd) begin
         if (is_reg(paddr, lsb_pkg::OFF_STATUS)) begin
            prdata_d = {28'h0000000, status_q};
            st_read_d = 1'b1;
         end else if (is_reg(paddr, lsb_pkg::OFF_DATA)) begin
            prdata_d = {24'h000000, data_q};
            if (st_read_q) begin
               status_d[lsb_pkg::ST_HERR] = 1'b0; // [R5]
               status_d[lsb_pkg::ST_RXF] = 1'b0;
            end
            st_read_d = 1'b0;
         end else if (is_reg(paddr, lsb_pkg::OFF_CTRL1)) prdata_d = {31'h0, wls_q};
         else if (is_reg(paddr, lsb_pkg::OFF_CTRL2))
            prdata_d = {28'h0000000, rxon_q, mute_q, txon_q, brk_q};
         else if (is_reg(paddr, lsb_pkg::OFF_CTRL3)) prdata_d = {31'h0, lin_q};
         else if (is_reg(paddr, lsb_pkg::OFF_HLEN)) prdata_d = {24'h000000, hlen_q};
         else if (is_reg(paddr, lsb_pkg::OFF_MASK)) prdata_d = {28'h0000000, mask_q};
         else if (is_reg(paddr, lsb_pkg::OFF_BAUD)) prdata_d = {16'h0000, baud_q};
         else pslverr_d = 1'b1;
      end
      if (wr) begin
         if (is_reg(paddr, lsb_pkg::OFF_STATUS)) status_d = status_q & ~pwdata[3:0];
         else if (is_reg(paddr, lsb_pkg::OFF_CTRL1)) wls_d = pwdata[lsb_pkg::C1_WLS];
         else if (is_reg(paddr, lsb_pkg::OFF_CTRL2)) begin
            brk_d = pwdata[lsb_pkg::C2_BRK];
            txon_d = pwdata[lsb_pkg::C2_TXON];
            if (pwdata[lsb_pkg::C2_MUTE]) mute_d = 1'b1; // [R6]
            else mute_d = 1'b0;
            rxon_d = pwdata[lsb_pkg::C2_RXON];
            if (pwdata[lsb_pkg::C2_BRK]) brk_req_d = 1'b1; // [R7]
            if (!txon_q && pwdata[lsb_pkg::C2_TXON]) idle_req_d = 1'b1; // [R10]
         end
         else if (is_reg(paddr, lsb_pkg::OFF_CTRL3)) lin_d = pwdata[lsb_pkg::C3_LIN];
         else if (is_reg(paddr, lsb_pkg::OFF_MASK)) mask_d = pwdata[3:0];
         else if (is_reg(paddr, lsb_pkg::OFF_BAUD)) baud_d = pwdata[15:0];
         else if (!is_reg(paddr, lsb_pkg::OFF_DATA) && !is_reg(paddr, lsb_pkg::OFF_HLEN))
            pslverr_d = 1'b1;
      end
      if (txs_q == lsb_pkg::TX_GAP) idle_req_d = 1'b0;
      // hardware sets win over software clears
      if (hd_timeout) begin
         status_d[lsb_pkg::ST_HERR] = 1'b1; // [R1]
         hlen_d = lsb_pkg::HLEN_TIMEOUT; // [R4]
         mute_d = 1'b1; // [R3]
      end
      if (hd_found) begin
         status_d[lsb_pkg::ST_HDF] = 1'b1;
         hlen_d = hbits_q;
         mute_d = 1'b0;
      end
      if (rb_done && !mute_q && rxon_q && !rb_fr && hds_q == lsb_pkg::HD_DATA || rb_done && !mute_q
          && rxon_q && !rb_fr && !lin_q) begin
         status_d[lsb_pkg::ST_RXF] = 1'b1; // [R6]
         data_d = rb_data;
      end
      if (txs_q == lsb_pkg::TX_BREAK && tick && tsmp_q == lsb_pkg::SAMPLE_LAST && tbit_q == 5'h01)
         status_d[lsb_pkg::ST_TXDONE] = 1'b1;
      irq_d = |(status_d & mask_d);
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         status_q <= 4'h0;
         mask_q <= 4'h0;
         data_q <= 8'h00;
         wls_q <= 1'b0;
         lin_q <= 1'b0;
         brk_q <= 1'b0;
         txon_q <= 1'b0;
         mute_q <= 1'b0;
         rxon_q <= 1'b0;
         hlen_q <= 8'h00;
         baud_q <= lsb_pkg::BAUD_RST;
         st_read_q <= 1'b0;
         idle_req_q <= 1'b0;
         brk_req_q <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         status_q <= status_d;
         mask_q <= mask_d;
         data_q <= data_d;
         wls_q <= wls_d;
         lin_q <= lin_d;
         brk_q <= brk_d;
         txon_q <= txon_d;
         mute_q <= mute_d;
         rxon_q <= rxon_d;
         hlen_q <= hlen_d;
         baud_q <= baud_d;
         st_read_q <= st_read_d;
         idle_req_q <= idle_req_d;
         brk_req_q <= brk_req_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         irq_out <= irq_d;
      end
   end

   // break and idle generator; a short send-break pulse is latched so it outlives a running idle
   always_comb begin
      txs_d = txs_q;
      tsmp_d = tsmp_q;
      tbit_d = tbit_q;
      tx_d = 1'b1;
      case (txs_q)
         lsb_pkg::TX_IDLE: begin
            if (txon_q && idle_req_q) begin
               txs_d = lsb_pkg::TX_GAP;
               tbit_d = lsb_pkg::IDLE_BITS; // [R12]
               tsmp_d = 4'h0;
            end else if (txon_q && (brk_q || brk_req_q)) begin
               txs_d = lsb_pkg::TX_BREAK;
               tsmp_d = 4'h0;
               if (lin_q && !wls_q) tbit_d = lsb_pkg::BRK_BITS_LIN; // [R9]
               else tbit_d = wls_q ? lsb_pkg::BRK_BITS_9 : lsb_pkg::BRK_BITS_8; // [R7]
               tx_d = 1'b0;
            end
         end
         lsb_pkg::TX_GAP, lsb_pkg::TX_BREAK: begin
            tx_d = (txs_q == lsb_pkg::TX_GAP); // [R13]
            if (tick) begin
               tsmp_d = tsmp_q + 4'h1;
               if (tsmp_q == lsb_pkg::SAMPLE_LAST) begin
                  tbit_d = tbit_q - 5'h01;
                  if (tbit_q == 5'h01) begin
                     txs_d = lsb_pkg::TX_IDLE; // [R8]
                     tx_d = 1'b1;
                  end
               end
            end
         end
         default: txs_d = lsb_pkg::TX_IDLE;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         txs_q <= lsb_pkg::TX_IDLE;
         tsmp_q <= 4'h0;
         tbit_q <= 5'h00;
         tx_out <= 1'b1;
      end else begin
         txs_q <= txs_d;
         tsmp_q <= tsmp_d;
         tbit_q <= tbit_d;
         tx_out <= tx_d;
      end
   end
endmodule
`default_nettype wire

// *** verif/lsb_bus_node.sv ***
`timescale 1ns/1ps
`default_nettype none
// far bus node: drives the receive line, and drives it high itself when idle
module lsb_bus_node #(
   parameter int BIT = 16
) (
   // clock
   input wire logic clock_in,
   // bus line
   output var logic line_out
);
   initial line_out = 1'b1;
   task automatic hold(input logic v, input int nb);
      line_out <= v;
      repeat (nb * BIT) @(posedge clock_in);
   endtask
   // start bit, eight data bits lsb first, stop bit
   task automatic send(input logic [7:0] b);
      int i;
      hold(1'b0, 1);
      for (i = 0; i < 8; i++) hold(b[i], 1);
      hold(1'b1, 1);
   endtask
endmodule
`default_nettype wire

// *** verif/lsb_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsb_props (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // serial line and interrupt
   input wire logic rx_in,
   input wire logic tx_out,
   input wire logic irq_out
);
   logic [15:0] baud_q;
   logic [3:0] mask_q;
   logic txon_q;
   logic arm_q;
   int low_q;
   int hi_q;
   int bit_w;
   logic wr_ok;
   // the design takes writes at the first access edge, before pready rises
   assign wr_ok = psel && penable && pwrite && !pready;
   assign bit_w = 16 * (int'(baud_q) + 1);
   // shadow copies of divisor, mask and tx_on; run lengths of tx_out
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         baud_q <= lsb_pkg::BAUD_RST;
         mask_q <= 4'h0;
         txon_q <= 1'b0;
         arm_q <= 1'b0;
         low_q <= 0;
         hi_q <= 0;
      end else begin
         if (wr_ok && paddr == lsb_pkg::OFF_BAUD) baud_q <= pwdata[15:0];
         if (wr_ok && paddr == lsb_pkg::OFF_MASK) mask_q <= pwdata[3:0];
         if (wr_ok && paddr == lsb_pkg::OFF_CTRL2) txon_q <= pwdata[lsb_pkg::C2_TXON];
         if (wr_ok && paddr == lsb_pkg::OFF_CTRL2 && pwdata[lsb_pkg::C2_TXON] && !txon_q) begin
            arm_q <= 1'b1;
            hi_q <= 0;
         end else begin
            if (!tx_out) arm_q <= 1'b0;
            hi_q <= tx_out ? hi_q + 1 : 0;
         end
         low_q <= tx_out ? 0 : low_q + 1;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   chk_brk_len: assert property ($rose(tx_out) |->
      (low_q == 10 * bit_w || low_q == 11 * bit_w || low_q == 13 * bit_w))
      else $error("break low time not 10, 11 or 13 bits");
   chk_brk_max: assert property (!tx_out |-> low_q < 13 * bit_w)
      else $error("transmit line low longer than 13 bits");
   chk_idle_gap: assert property ($fell(tx_out) && arm_q |-> hi_q >= 10 * bit_w)
      else $error("break after idle request came before 10 idle bits");
   chk_rst_idle: assert property ($fell(rst_in) |-> tx_out && !irq_out && !pready)
      else $error("outputs not idle after reset");
   chk_irq_mask: assert property (irq_out |-> (mask_q != 4'h0 || $past(mask_q) != 4'h0))
      else $error("interrupt high with all sources masked");
   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready not one cycle after access");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_slverr_map: assert property (pready |-> pslverr == (paddr > lsb_pkg::OFF_BAUD))
      else $error("pslverr does not match address map");
   chk_status_width: assert property (pready && !pwrite && paddr == lsb_pkg::OFF_STATUS
      |-> prdata[31:4] == 28'h0000000)
      else $error("status read has upper bits set");
   cover property ($rose(tx_out));
   cover property ($rose(irq_out));
   cover property (pready && pslverr);
endmodule
bind lsb_top lsb_props lsb_props_i (.clock_in(clock_in), .rst_in(rst_in), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .irq_out(irq_out));
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] TXON = 32'h1 << lsb_pkg::C2_TXON;
   localparam logic [31:0] BRK = 32'h1 << lsb_pkg::C2_BRK;
   localparam logic [31:0] LSN = (32'h1 << lsb_pkg::C2_MUTE) | (32'h1 << lsb_pkg::C2_RXON);
   logic clock_in, rst_in, psel, penable, pwrite, pready, pslverr, rx_in, tx_out, irq_out;
   logic [7:0] paddr;
   logic [7:0] rb;
   logic [31:0] pwdata, prdata, rv;
   logic err_q;
   int n_fail, n_tests, seed, i, hi, lo;
   lsb_top lsb_top_i (.clock_in(clock_in), .rst_in(rst_in), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .irq_out(irq_out));
   lsb_bus_node lsb_bus_node_i (.clock_in(clock_in), .line_out(rx_in));
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic tmo;
      n_fail++;
      $display("ERROR wait expected done seen timeout");
      finish_test();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      do begin
         @(posedge clock_in);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) tmo();
      rv = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h00000000);
   endtask
   // high cycles until tx_out falls, then low cycles until it rises
   task automatic meas;
      int k;
      k = 0;
      hi = 0;
      lo = 0;
      while (tx_out !== 1'b0 && k < 5000) begin
         @(posedge clock_in);
         hi++;
         k++;
      end
      while (tx_out === 1'b0 && k < 5000) begin
         @(posedge clock_in);
         lo++;
         k++;
      end
      if (k >= 5000) tmo();
   endtask
   function automatic int brk_bits(input logic nine, input logic lin);
      return nine ? 11 : (lin ? 13 : 10);
   endfunction
   task automatic header(input logic [7:0] id, input int stall);
      lsb_bus_node_i.hold(1'b0, 13);
      lsb_bus_node_i.hold(1'b1, 1);
      lsb_bus_node_i.send(lsb_pkg::SYNC_BYTE);
      lsb_bus_node_i.hold(1'b1, stall);
      if (stall < 40) lsb_bus_node_i.send(id);
      lsb_bus_node_i.hold(1'b1, 2);
   endtask
   initial begin
      seed = 99849;
      n_fail = 0;
      n_tests = 0;
      rst_in = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      repeat (20) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      rd(lsb_pkg::OFF_BAUD);
      cmp("baud_reset", {16'h0000, lsb_pkg::BAUD_RST}, rv);
      rd(8'h20);
      cmp("unmapped_err", 32'h1, err_q);
      wr(lsb_pkg::OFF_BAUD, 32'h0);
      wr(lsb_pkg::OFF_MASK, 32'hF);
      $display("test registers done");
      for (i = 0; i < 4; i++) begin
         wr(lsb_pkg::OFF_CTRL1, i & 1);
         wr(lsb_pkg::OFF_CTRL3, i >> 1);
         wr(lsb_pkg::OFF_CTRL2, 32'h0);
         wr(lsb_pkg::OFF_CTRL2, TXON);
         wr(lsb_pkg::OFF_CTRL2, TXON | BRK);
         wr(lsb_pkg::OFF_CTRL2, TXON);
         meas();
         cmp("idle_gap", 32'h1, 32'(hi >= 150));
         cmp("break_len", brk_bits(i[0], i[1]) * 16, lo);
      end
      $display("test break lengths done");
      wr(lsb_pkg::OFF_CTRL1, 32'h0);
      wr(lsb_pkg::OFF_CTRL3, 32'h0);
      wr(lsb_pkg::OFF_CTRL2, TXON | BRK);
      meas();
      cmp("break_held_1", 32'd160, lo);
      meas();
      cmp("break_held_2", 32'd160, lo);
      wr(lsb_pkg::OFF_CTRL2, TXON);
      repeat (400) @(posedge clock_in);
      $display("test held break done");
      wr(lsb_pkg::OFF_CTRL3, 32'h1);
      wr(lsb_pkg::OFF_CTRL2, LSN);
      wr(lsb_pkg::OFF_STATUS, 32'hF);
      header(8'h00, 60);
      lsb_bus_node_i.send(8'hA5);
      lsb_bus_node_i.hold(1'b1, 2);
      rd(lsb_pkg::OFF_STATUS);
      cmp("timeout_status", 32'h4, rv & 32'h7);
      cmp("timeout_irq", 32'h1, irq_out);
      rd(lsb_pkg::OFF_HLEN);
      cmp("timeout_hlen", lsb_pkg::HLEN_TIMEOUT, rv);
      wr(lsb_pkg::OFF_MASK, 32'h0);
      repeat (2) @(posedge clock_in);
      cmp("masked_irq", 32'h0, irq_out);
      wr(lsb_pkg::OFF_MASK, 32'hF);
      rd(lsb_pkg::OFF_DATA);
      rd(lsb_pkg::OFF_STATUS);
      cmp("herr_cleared", 32'h0, rv[lsb_pkg::ST_HERR]);
      $display("test header timeout done");
      wr(lsb_pkg::OFF_STATUS, 32'hF);
      rb = 8'($random(seed));
      header({2'b00, rb[5:0]}, 0);
      rd(lsb_pkg::OFF_STATUS);
      cmp("header_found", 32'h1, rv[lsb_pkg::ST_HDF]);
      wr(lsb_pkg::OFF_STATUS, 32'hF);
      rb = 8'($random(seed));
      lsb_bus_node_i.send(rb);
      lsb_bus_node_i.hold(1'b1, 2);
      rd(lsb_pkg::OFF_STATUS);
      cmp("rx_full", 32'h1, rv[lsb_pkg::ST_RXF]);
      rd(lsb_pkg::OFF_DATA);
      cmp("rx_data", {24'h0, rb}, rv);
      wr(lsb_pkg::OFF_CTRL2, LSN);
      wr(lsb_pkg::OFF_STATUS, 32'hF);
      lsb_bus_node_i.send(~rb);
      lsb_bus_node_i.hold(1'b1, 2);
      rd(lsb_pkg::OFF_STATUS);
      cmp("muted_rx_full", 32'h0, rv[lsb_pkg::ST_RXF]);
      $display("test header receive done");
      // time-out while unmuted and with a non-zero header length left from the last header
      wr(lsb_pkg::OFF_CTRL2, 32'h1 << lsb_pkg::C2_RXON);
      wr(lsb_pkg::OFF_STATUS, 32'hF);
      header(8'h00, 60);
      rd(lsb_pkg::OFF_STATUS);
      cmp("timeout2_status", 32'h4, rv & 32'h7);
      rd(lsb_pkg::OFF_CTRL2);
      cmp("timeout2_mute", 32'h1, rv[lsb_pkg::C2_MUTE]);
      rd(lsb_pkg::OFF_HLEN);
      cmp("timeout2_hlen", lsb_pkg::HLEN_TIMEOUT, rv);
      $display("test unmuted header timeout done");
      finish_test();
   end
endmodule
`default_nettype wire
